// ==== core/ccs_defs.svh ====
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ==========================================================
// register offsets
`define CCS_OFF_INTERRUPT_SEND 16'h1040
`define CCS_OFF_MAILBOX_SEND   16'h1048
`define CCS_OFF_FREQUENCY_SEND 16'h1058
`define CCS_OFF_REMOTE_SEND    16'h1158
`define CCS_OFF_FREQ_CFG       16'h1050

// ==========================================================
// field positions
`define CCS_WAIT_BIT           31
`define CCS_MASK_HI            30
`define CCS_MASK_LO            27
`define CCS_CORE_HI            25
`define CCS_CORE_LO            16
`define CCS_VEC_HI             4
`define CCS_SEL_HI             4
`define CCS_SEL_LO             2
`define CCS_FREQ_HI            4
`define CCS_OFF_HI             15
`define CCS_DATA_HI            63
`define CCS_DATA_LO            32

// ==========================================================
// reset values
`define CCS_REQ_RESET          65'h0
`define CCS_RDATA_RESET        64'h0

`endif

// ==== core/ccs_pkg.sv ====
package ccs_pkg;

    typedef enum logic [1:0] {
        CCS_KIND_IRQ  = 2'b00,
        CCS_KIND_MAIL = 2'b01,
        CCS_KIND_FREQ = 2'b10,
        CCS_KIND_REG  = 2'b11
    } ccs_kind_t;

    // one write from the configuration-register instruction path
    typedef struct packed {
        logic [15:0] addr;
        logic [63:0] data;
    } ccs_wr_t;

    // one action delivered to a target core
    typedef struct packed {
        ccs_kind_t   kind;
        logic [9:0]  core;
        logic        wait_done;
        logic [15:0] index;
        logic [31:0] data;
        logic [3:0]  byte_en;
    } ccs_req_t;

endpackage

// ==== core/ccs_decode.sv ====
`timescale 1ns/1ps
`include "ccs_defs.svh"

module ccs_decode import ccs_pkg::*; #(
    parameter int NUM_CORES = 16
) (
    input  wire ccs_wr_t  wr_in,      // write to decode
    output ccs_req_t      req_out,    // decoded action
    output logic          hit_out,    // address is a send register
    output logic          core_ok_out // target core exists
);

    logic [31:0] wdata_hi;
    logic [9:0]  core_num;
    logic [3:0]  keep_bytes;

    assign wdata_hi   = wr_in.data[`CCS_DATA_HI:`CCS_DATA_LO];
    assign core_num   = wr_in.data[`CCS_CORE_HI:`CCS_CORE_LO];
    assign keep_bytes = ~wr_in.data[`CCS_MASK_HI:`CCS_MASK_LO];
    assign core_ok_out = 32'(core_num) < NUM_CORES;

    // ==========================================================
    // field decode; reserved bits are never looked at
    always_comb begin
        req_out           = '0;
        req_out.core      = core_num;
        req_out.wait_done = wr_in.data[`CCS_WAIT_BIT];
        hit_out           = 1'b1;
        unique case (wr_in.addr)
            `CCS_OFF_INTERRUPT_SEND: begin
                req_out.kind    = CCS_KIND_IRQ;
                req_out.index   = {11'h0, wr_in.data[`CCS_VEC_HI:0]};
                req_out.data    = 32'h1 << wr_in.data[`CCS_VEC_HI:0];
                req_out.byte_en = 4'hf;
            end
            `CCS_OFF_MAILBOX_SEND: begin
                req_out.kind    = CCS_KIND_MAIL;
                req_out.index   = {13'h0, wr_in.data[`CCS_SEL_HI:`CCS_SEL_LO]};
                req_out.data    = wdata_hi;
                req_out.byte_en = keep_bytes;
            end
            `CCS_OFF_FREQUENCY_SEND: begin
                req_out.kind    = CCS_KIND_FREQ;
                req_out.index   = `CCS_OFF_FREQ_CFG;
                req_out.data    = {27'h0, wr_in.data[`CCS_FREQ_HI:0]};
                req_out.byte_en = 4'hf;
            end
            `CCS_OFF_REMOTE_SEND: begin
                req_out.kind    = CCS_KIND_REG;
                req_out.index   = wr_in.data[`CCS_OFF_HI:0];
                req_out.data    = wdata_hi;
                req_out.byte_en = keep_bytes;
            end
            default: begin
                hit_out = 1'b0;
            end
        endcase
    end

endmodule

// ==== core/ccs_send.sv ====
`timescale 1ns/1ps
`include "ccs_defs.svh"

// Notes on behaviour
// - send registers write-only; reads return zero
// - write delivered only to an existing core at a send offset
// - interrupt send at 0x1040 raises interrupt
// - bits 4:0 pick target status vector bit
// - bits 25:16 name the target core
// - bit 31 holds write until target done, except frequency send
// - mailbox send at 0x1048, data bits 63:32
// - bits 30:27 mask bytes, one suppresses
// - bits 4:2 select one of 8 mailbox entries
// - frequency send at 0x1058 writes 0x1050
// - any-register send at 0x1158, offset 15:0

module ccs_send import ccs_pkg::*; #(
    parameter int NUM_CORES = 16
) (
    input  wire logic     core_clk_in,     // core clock
    input  wire logic     reset_in,        // async reset, high
    input  wire logic     cfg_wr_in,       // config write strobe
    input  wire ccs_wr_t  cfg_wr_data_in,  // write address and data
    output logic          cfg_ready_out,   // write may be taken
    output logic          cfg_wr_ack_out,  // write completed, pulse
    input  wire logic     cfg_rd_in,       // config read strobe
    output logic          cfg_rd_ack_out,  // read answer, pulse
    output logic [63:0]   cfg_rdata_out,   // read data, always zero
    output logic          req_valid_out,   // action to target valid
    input  wire logic     req_ready_in,    // target fabric takes action
    output ccs_req_t      req_out,         // action to target core
    input  wire logic     req_done_in      // action took effect, pulse
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_WAIT = 2'b10
    } ccs_state_t;

    ccs_state_t  state;
    ccs_state_t  next_state;
    ccs_req_t    req;
    ccs_req_t    next_req;
    logic        wr_ack;
    logic        next_wr_ack;
    logic        rd_ack;
    logic        next_rd_ack;
    logic [63:0] rdata;
    logic [63:0] next_rdata;

    ccs_req_t    dec_req;
    logic        dec_hit;
    logic        dec_core_ok;
    logic        accept;

    // ==========================================================
    // decode
    ccs_decode #(
        .NUM_CORES (NUM_CORES)
    ) u_decode (
        .wr_in       (cfg_wr_data_in),
        .req_out     (dec_req),
        .hit_out     (dec_hit),
        .core_ok_out (dec_core_ok)
    );

    // writes while busy are dropped silently; the issuer watches ready
    assign accept         = cfg_wr_in && (state == ST_IDLE);
    assign cfg_ready_out  = (state == ST_IDLE);
    assign req_valid_out  = (state == ST_SEND);
    assign req_out        = req;
    assign cfg_wr_ack_out = wr_ack;
    assign cfg_rd_ack_out = rd_ack;
    assign cfg_rdata_out  = rdata;

    // ==========================================================
    // delivery sequencer
    always_comb begin
        next_state  = state;
        next_req    = req;
        next_wr_ack = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (accept) begin
                    if (dec_hit && dec_core_ok) begin
                        next_req   = dec_req;
                        next_state = ST_SEND;
                    end else begin
                        next_wr_ack = 1'b1;
                    end
                end
            end
            ST_SEND: begin
                if (req_ready_in) begin
                    // frequency updates report no effect back, so never wait
                    if (req.wait_done && (req.kind != CCS_KIND_FREQ)) begin
                        next_state = ST_WAIT;
                    end else begin
                        next_wr_ack = 1'b1;
                        next_state  = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (req_done_in) begin
                    next_wr_ack = 1'b1;
                    next_state  = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state  <= ST_IDLE;
            req    <= `CCS_REQ_RESET;
            wr_ack <= 1'b0;
        end else begin
            state  <= next_state;
            req    <= next_req;
            wr_ack <= next_wr_ack;
        end
    end

    // ==========================================================
    // read path: nothing readable
    // every read is answered so a stray read never hangs the core
    always_comb begin
        next_rd_ack = cfg_rd_in;
        next_rdata  = `CCS_RDATA_RESET;
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_ack <= 1'b0;
            rdata  <= `CCS_RDATA_RESET;
        end else begin
            rd_ack <= next_rd_ack;
            rdata  <= next_rdata;
        end
    end

    // ==========================================================
    // checks
    sequence s_taken_good;
        accept && dec_hit && dec_core_ok;
    endsequence

    sequence s_handed;
        req_valid_out && req_ready_in;
    endsequence

    sequence s_wait_handed;
        s_handed ##0 (req_out.wait_done && (req_out.kind != CCS_KIND_FREQ));
    endsequence

    sequence s_freq_handed;
        s_handed ##0 (req_out.kind == CCS_KIND_FREQ);
    endsequence

    rd_zero_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        cfg_rd_in |=> cfg_rd_ack_out && (cfg_rdata_out == 64'h0))
        else $error("read of send register returned data");

    deliver_start_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good |=> req_valid_out && (req_out.core == $past(cfg_wr_data_in.data[25:16])))
        else $error("good write not offered to target");

    irq_vector_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr == `CCS_OFF_INTERRUPT_SEND) |=>
            (req_out.kind == CCS_KIND_IRQ) && (req_out.index[4:0] == $past(cfg_wr_data_in.data[4:0]))
            && (req_out.data == (32'h1 << $past(cfg_wr_data_in.data[4:0]))))
        else $error("interrupt vector not carried");

    req_hold_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        req_valid_out && !req_ready_in |=> req_valid_out && $stable(req_out))
        else $error("request changed while stalled");

    // ==========================================================
    // checks: completion of the issuing write, field decode and dropped writes
    wait_hold_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_wait_handed |=> !cfg_wr_ack_out && !cfg_ready_out && !req_valid_out)
        else $error("waiting write completed before target done");

    wait_enter_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_wait_handed |=> (state == ST_WAIT))
        else $error("waiting write did not wait");

    wait_stay_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (state == ST_WAIT) && !req_done_in |=> (state == ST_WAIT) && !cfg_wr_ack_out)
        else $error("waiting write left before target done");

    wait_end_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (state == ST_WAIT) && req_done_in |=> cfg_wr_ack_out && cfg_ready_out)
        else $error("waiting write not completed after done");

    no_wait_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_handed ##0 !req_out.wait_done |=> cfg_wr_ack_out && cfg_ready_out)
        else $error("posted write not completed at hand-off");

    byte_mask_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr inside {`CCS_OFF_MAILBOX_SEND, `CCS_OFF_REMOTE_SEND}) |=>
            (req_out.byte_en == ~$past(cfg_wr_data_in.data[30:27]))
            && (req_out.data == $past(cfg_wr_data_in.data[63:32])))
        else $error("byte mask or data wrong");

    mbox_sel_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr == `CCS_OFF_MAILBOX_SEND) |=>
            (req_out.kind == CCS_KIND_MAIL) && (req_out.index == {13'h0, $past(cfg_wr_data_in.data[4:2])}))
        else $error("mailbox selector wrong");

    freq_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr == `CCS_OFF_FREQUENCY_SEND) |=>
            (req_out.index == `CCS_OFF_FREQ_CFG) && (req_out.data == {27'h0, $past(cfg_wr_data_in.data[4:0])}))
        else $error("frequency update wrong");

    any_off_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr == `CCS_OFF_REMOTE_SEND) |=>
            (req_out.kind == CCS_KIND_REG) && (req_out.index == $past(cfg_wr_data_in.data[15:0])))
        else $error("remote register offset wrong");

    drop_core_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        accept && !dec_core_ok |=> !req_valid_out && cfg_wr_ack_out && cfg_ready_out)
        else $error("write to missing core not dropped");

    drop_addr_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        accept && !dec_hit |=> !req_valid_out && cfg_wr_ack_out)
        else $error("write to unmapped offset not dropped");

    core_range_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        req_valid_out |-> (32'(req_out.core) < NUM_CORES))
        else $error("action offered for missing core");

    irq_bytes_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr == `CCS_OFF_INTERRUPT_SEND) |=>
            (req_out.byte_en == 4'hf) && (req_out.core == $past(cfg_wr_data_in.data[25:16])))
        else $error("interrupt action malformed");

    freq_bytes_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good ##0 (cfg_wr_data_in.addr == `CCS_OFF_FREQUENCY_SEND) |=>
            (req_out.kind == CCS_KIND_FREQ) && (req_out.byte_en == 4'hf))
        else $error("frequency action malformed");

    wait_flag_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_taken_good |=> (req_out.wait_done == $past(cfg_wr_data_in.data[31])))
        else $error("wait flag not carried");

    freq_post_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_freq_handed |=> cfg_wr_ack_out && cfg_ready_out)
        else $error("frequency write not completed at hand-off");

    // ==========================================================
    // checks: handshake hygiene
    send_busy_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        req_valid_out |-> !cfg_ready_out && !cfg_wr_ack_out)
        else $error("write completed before delivery");

    ready_back_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        cfg_wr_ack_out |-> cfg_ready_out)
        else $error("write completed while still busy");

    ack_once_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        cfg_wr_ack_out && !cfg_wr_in |=> !cfg_wr_ack_out)
        else $error("write completion longer than one cycle");

    idle_quiet_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        cfg_ready_out && !cfg_wr_in |=> !req_valid_out && !cfg_wr_ack_out)
        else $error("action without a write");

    done_ignored_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        req_done_in && cfg_ready_out && !cfg_wr_in |=> !cfg_wr_ack_out)
        else $error("stray done completed a write");

    rd_once_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        !cfg_rd_in |=> !cfg_rd_ack_out)
        else $error("read answer without read");

    rd_no_side_a: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        cfg_rd_in && cfg_ready_out && !cfg_wr_in |=> cfg_ready_out && !req_valid_out)
        else $error("read caused an action");

endmodule

// ==== verification/ccs_target_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// target core stand-in: stalls, takes actions, signals effect
module ccs_target_model import ccs_pkg::*; (
    input  wire logic       core_clk_in,   // core clock
    input  wire logic       reset_in,      // async reset, high
    input  wire logic [3:0] delay_in,      // stall and effect delay
    input  wire logic       req_valid_in,  // action offered
    input  wire ccs_req_t   req_in,        // action
    output logic            req_ready_out, // action taken
    output logic            req_done_out,  // effect pulse
    output ccs_req_t        got_out,       // last action taken
    output logic [15:0]     taken_out,     // actions taken
    output logic [15:0]     dones_out      // effect pulses sent
);
    logic [3:0] stall_cnt;
    logic [3:0] done_cnt;
    logic       pending;

    assign req_ready_out = req_valid_in && (stall_cnt >= delay_in);

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stall_cnt    <= 4'h0;
            done_cnt     <= 4'h0;
            pending      <= 1'b0;
            req_done_out <= 1'b0;
            got_out      <= '0;
            taken_out    <= 16'h0;
            dones_out    <= 16'h0;
        end else begin
            req_done_out <= 1'b0;
            if (pending) begin
                if (done_cnt == 4'h0) begin
                    req_done_out <= 1'b1;
                    pending      <= 1'b0;
                    dones_out    <= dones_out + 16'h1;
                end else begin
                    done_cnt <= done_cnt - 4'h1;
                end
            end
            if (req_valid_in && req_ready_out) begin
                got_out   <= req_in;
                taken_out <= taken_out + 16'h1;
                stall_cnt <= 4'h0;
                if (req_in.wait_done && (req_in.kind != CCS_KIND_FREQ)) begin
                    pending  <= 1'b1;
                    done_cnt <= delay_in;
                end
            end else if (req_valid_in) begin
                stall_cnt <= stall_cnt + 4'h1;
            end
        end
    end
endmodule

// ==== verification/cross_core_send_registers_tb_top.sv ====
`timescale 1ns/1ps
module cross_core_send_registers_tb_top import ccs_pkg::*; ;
    logic        core_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        cfg_wr_in = 1'b0;
    logic        cfg_rd_in = 1'b0;
    ccs_wr_t     cfg_wr_data_in = '0;
    logic        cfg_ready_out, cfg_wr_ack_out, cfg_rd_ack_out, req_valid_out, req_ready_in, req_done_in;
    logic [63:0] cfg_rdata_out, rnd;
    ccs_req_t    req_out, got;
    logic [15:0] taken, dones;
    logic [3:0]  dly = 4'h0;
    logic [15:0] offs [5] = '{16'h1040, 16'h1048, 16'h1058, 16'h1158, 16'h1050};
    logic [63:0] corner [5] = '{64'hdeadbeef_400f001f, 64'h12345678_80000000, 64'hffffffff_80100003,
                                64'h0badf00d_ac03ffe3, 64'h00000000_03ff0000};
    int          bad_count = 0;
    int          n_compared = 0;

    ccs_send u_dut (.core_clk_in, .reset_in, .cfg_wr_in, .cfg_wr_data_in, .cfg_ready_out, .cfg_wr_ack_out,
                    .cfg_rd_in, .cfg_rd_ack_out, .cfg_rdata_out, .req_valid_out, .req_ready_in, .req_out,
                    .req_done_in);
    ccs_target_model u_tgt (.core_clk_in, .reset_in, .delay_in(dly), .req_valid_in(req_valid_out),
                            .req_in(req_out), .req_ready_out(req_ready_in), .req_done_out(req_done_in),
                            .got_out(got), .taken_out(taken), .dones_out(dones));

    initial begin
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [63:0] act, input logic [63:0] exp);
        n_compared++;
        if (act !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, act, exp);
        end
    endtask

    task automatic check_req(input ccs_req_t act, input ccs_req_t exp);
        n_compared++;
        if (act !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: action got %h want %h", $time, act, exp);
        end
    endtask

    task automatic tick;
        @(posedge core_clk_in);
        #1;
    endtask

    // expected action for one send-register write
    function automatic ccs_req_t exp_req(input ccs_wr_t w);
        ccs_req_t r;
        r.core = w.data[25:16];
        r.wait_done = w.data[31];
        r.data = w.data[63:32];
        r.byte_en = ~w.data[30:27];
        case (w.addr)
            16'h1040: begin
                r.kind = CCS_KIND_IRQ;
                r.index = {11'h0, w.data[4:0]};
                r.data = 32'h1 << w.data[4:0];
                r.byte_en = 4'hf;
            end
            16'h1048: begin
                r.kind = CCS_KIND_MAIL;
                r.index = {13'h0, w.data[4:2]};
            end
            16'h1058: begin
                r.kind = CCS_KIND_FREQ;
                r.index = 16'h1050;
                r.data = {27'h0, w.data[4:0]};
                r.byte_en = 4'hf;
            end
            default: begin
                r.kind = CCS_KIND_REG;
                r.index = w.data[15:0];
            end
        endcase
        return r;
    endfunction

    task automatic do_write(input logic [15:0] a, input logic [63:0] d);
        ccs_wr_t     w;
        ccs_req_t    e;
        logic        hit;
        logic [15:0] t0, d0;
        int          n;
        w = '{addr: a, data: d};
        e = exp_req(w);
        hit = (a == 16'h1040 || a == 16'h1048 || a == 16'h1058 || a == 16'h1158) && d[25:16] < 10'h010;
        n = 0;
        tick();
        while (cfg_ready_out !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        t0 = taken;
        d0 = dones;
        cfg_wr_data_in = w;
        cfg_wr_in = 1'b1;
        tick();
        check_val("ready after take", 64'(cfg_ready_out), 64'(!hit));
        // while busy, a valid-looking write must be ignored
        cfg_wr_data_in.data = 64'h0;
        cfg_wr_in = hit;
        while (cfg_wr_ack_out !== 1'b1 && n < 200) begin
            tick();
            cfg_wr_in = 1'b0;
            n++;
        end
        if (n >= 200) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no write answer", $time);
            test_done();
        end
        check_val("delivered", 64'(taken - t0), 64'(hit));
        check_val("effect waited", 64'(dones - d0), 64'(hit && e.wait_done && e.kind != CCS_KIND_FREQ));
        if (hit) check_req(got, e);
    endtask

    initial begin
        void'($urandom(81));
        repeat (3) @(posedge core_clk_in);
        #1;
        reset_in = 1'b0;
        // back-to-back reads answer next cycle with zero
        cfg_rd_in = 1'b1;
        for (int i = 0; i < 3; i++) begin
            tick();
            if (i == 1) cfg_rd_in = 1'b0;
            check_val("read ack", 64'(cfg_rd_ack_out), 64'(i < 2));
            if (i < 2) check_val("read data", cfg_rdata_out, 64'h0);
        end
        $display("test reads done");
        foreach (offs[i]) begin
            foreach (corner[j]) begin
                dly = 4'(2 * j);
                do_write(offs[i], corner[j]);
            end
        end
        for (int s = 0; s < 8; s++) do_write(16'h1048, 64'ha5a5a5a5_88020000 | (64'(s) << 2));
        $display("test corners done");
        for (int k = 0; k < 80; k++) begin
            dly = 4'($urandom_range(0, 5));
            rnd = {$urandom, $urandom};
            rnd[25:16] = 10'($urandom_range(0, 17));
            do_write(offs[$urandom_range(0, 4)], rnd);
        end
        $display("test random done");
        test_done();
    end
endmodule
